// file: hw/isa_bridge_defs.svh
// address map, field positions and reset values of the expansion bridge
`ifndef ISA_BRIDGE_DEFS_SVH
`define ISA_BRIDGE_DEFS_SVH
`define IO_AW              16
`define MEM_AW             20
`define REG_LED_CONTROL    16'h01d0
`define REG_PRODUCT_REV    16'h01d1
`define REG_JUMPER_STATUS  16'h01d2
`define REG_RSVD_LO        16'h01d3
`define REG_RSVD_HI        16'h01d7
`define REG_SPI_LO         16'h01d8
`define REG_SPI_HI         16'h01dd
`define REG_IRQ_ROUTE      16'h01de
`define LED_BIT            7
`define LED_RESET          1'b0
`define PRODUCT_CODE_MSB   7
`define PRODUCT_CODE_LSB   3
`define CIRC_REV_MSB       2
`define CIRC_REV_LSB       0
`define IO_FWD_COUNT       7
`define IO_FWD_LO0         16'h0100
`define IO_FWD_HI0         16'h01cf
`define IO_FWD_LO1         16'h01df
`define IO_FWD_HI1         16'h01ef
`define IO_FWD_LO2         16'h0200
`define IO_FWD_HI2         16'h036f
`define IO_FWD_LO3         16'h03e8
`define IO_FWD_HI3         16'h03ef
`define IO_FWD_LO4         16'h03f8
`define IO_FWD_HI4         16'h047f
`define IO_FWD_LO5         16'h0490
`define IO_FWD_HI5         16'h04cf
`define IO_FWD_LO6         16'h04d2
`define IO_FWD_HI6         16'h0aff
`define SER_PORT_COUNT     4
`define SER1_BASE          16'h03f8
`define SER2_BASE          16'h02f8
`define SER3_BASE          16'h03e8
`define SER4_BASE          16'h02e8
`define SER_SPAN_MASK      16'hfff8
`define MEM_SYS_RAM_HI     20'h9ffff
`define MEM_VID_RAM_HI     20'hbffff
`define MEM_VID_BIOS_LO    20'hc0000
`define MEM_VID_BIOS_HI    20'hcffff
`define MEM_EXP_LO         20'hd0000
`define MEM_EXP_HI         20'hdbfff
`define MEM_RSVD_HI        20'hdffff
`define MEM_SYS_BIOS_LO    20'he0000
`define SHADOW_BLOCKS      16
`define SHADOW_BLK_SHIFT   14
`define IRQ_EXP_COUNT      4
`endif

// file: hw/isa_bridge_pkg.sv
// types shared by the expansion bridge
package isa_bridge_pkg;
  typedef enum logic [2:0] {
    MR_SYS_RAM, MR_VID_RAM, MR_VID_BIOS, MR_EXPANSION, MR_RESERVED, MR_SYS_BIOS
  } mem_region_e;
  typedef struct packed {
    logic        io;
    logic        mem;
    logic        rd;
    logic        wr;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        wide;
  } host_cycle_s;
  typedef struct packed {
    logic        io_fwd;
    logic        mem_fwd;
    logic        onboard;
    logic        shadow_hit;
    logic        force_8bit;
    mem_region_e region;
  } decode_s;
  typedef struct packed {
    logic       led_r;
    logic [7:0] rdata_r;
    logic       rvalid_r;
  } bridge_state_s;
endpackage

// file: hw/isa_expansion_decode_board_regs.sv
// host to expansion bus decoder with board control and product registers
// Summary of operation
// - forward host io cycles in the seven listed ranges to expansion bus
// - forward a serial port's range when that on-board port is disabled
// - forward memory d0000h-dbfffh to expansion bus, byte-wide transfers only
// - pass expansion irq 3, 4, 5, 10 to controller only when each enabled
// - an enabled expansion irq is not shared with an on-board source
// - no dma service; expansion dma requests never acknowledged
// - decode lower megabyte into ram, video, bios, expansion and reserved regions
// - blocks c0000h-fffffh shadow into ram per configuration enable
// - on-board registers at 1d0h-1deh claimed in io space
// - disabled on-board devices release their io; all registers at 1d0h-1deh stay claimed
// - control register bit 7 switches led on (1) or off (0)
// - control bits 6-0 have no function and drive no output
// - product register bits 7-3 return fixed product code, read only
// - product register bits 2-0 return fixed circuit revision, ignore writes
// - exactly four non-shared expansion irqs
`include "isa_bridge_defs.svh"
module isa_expansion_decode_board_regs
  import isa_bridge_pkg::*;
#(
  parameter logic [4:0] PRODUCT_CODE = 5'h1a, // arbitrary value
  parameter logic [2:0] CIRCUIT_REV  = 3'h4   // arbitrary value
)(
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  input  wire logic                          i_clk_en,
  // host cycle
  input  wire host_cycle_s                   i_host,
  // configuration settings
  input  wire logic [`SER_PORT_COUNT-1:0]    i_ser_enable,
  input  wire logic                          i_onboard_dev_en,
  input  wire logic [`SHADOW_BLOCKS-1:0]     i_shadow_en,
  input  wire logic [`IRQ_EXP_COUNT-1:0]     i_irq_enable,
  input  wire logic [`IRQ_EXP_COUNT-1:0]     i_onboard_irq_use,
  // expansion side
  input  wire logic [`IRQ_EXP_COUNT-1:0]     i_exp_irq,
  input  wire logic                          i_exp_dma_req,
  output logic                               o_exp_dma_ack,
  output logic                               o_exp_io_sel,
  output logic                               o_exp_mem_sel,
  output logic                               o_exp_8bit,
  // decode results
  output logic                               o_onboard_sel,
  output logic                               o_shadow_hit,
  output mem_region_e                        o_region,
  output logic [`IRQ_EXP_COUNT-1:0]          o_irq_to_pic,
  output logic [`IRQ_EXP_COUNT-1:0]          o_irq_conflict,
  // register read and led
  output logic [7:0]                         o_rdata,
  output logic                               o_rvalid,
  output logic                               o_led
);
  bridge_state_s state_r;
  bridge_state_s state_nxt;
  decode_s       dec;
  logic [`IO_AW-1:0] io_addr;
  logic [`IO_FWD_COUNT-1:0] io_hit;
  logic [`SER_PORT_COUNT-1:0] ser_hit;
  logic [`IO_AW-1:0] fwd_lo [`IO_FWD_COUNT];
  logic [`IO_AW-1:0] fwd_hi [`IO_FWD_COUNT];
  logic [`IO_AW-1:0] ser_base [`SER_PORT_COUNT];
  logic reg_space;
  logic ser_claim;
  logic ser_free;
  logic [3:0] blk;

  assign fwd_lo = '{`IO_FWD_LO0, `IO_FWD_LO1, `IO_FWD_LO2, `IO_FWD_LO3,
                    `IO_FWD_LO4, `IO_FWD_LO5, `IO_FWD_LO6};
  assign fwd_hi = '{`IO_FWD_HI0, `IO_FWD_HI1, `IO_FWD_HI2, `IO_FWD_HI3,
                    `IO_FWD_HI4, `IO_FWD_HI5, `IO_FWD_HI6};
  assign ser_base = '{`SER1_BASE, `SER2_BASE, `SER3_BASE, `SER4_BASE};
  assign io_addr = i_host.addr[`IO_AW-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < `IO_FWD_COUNT; gi++)
    begin : g_fwd
      assign io_hit[gi] = (io_addr >= fwd_lo[gi]) && (io_addr <= fwd_hi[gi]);
    end
    for (gi = 0; gi < `SER_PORT_COUNT; gi++)
    begin : g_ser
      assign ser_hit[gi] = (io_addr & `SER_SPAN_MASK) == ser_base[gi];
    end
  endgenerate

  // a port range is free only when every enabled port leaves it alone
  assign ser_free  = |(ser_hit & ~i_ser_enable);
  assign ser_claim = |(ser_hit & i_ser_enable);
  assign reg_space = (io_addr >= `REG_LED_CONTROL) && (io_addr <= `REG_IRQ_ROUTE);
  assign blk = i_host.addr[`SHADOW_BLK_SHIFT+3:`SHADOW_BLK_SHIFT];

  always_comb
  begin
    dec = '0;
    dec.region = MR_SYS_RAM;
    if (i_host.addr <= `MEM_SYS_RAM_HI)
      dec.region = MR_SYS_RAM;
    else if (i_host.addr <= `MEM_VID_RAM_HI)
      dec.region = MR_VID_RAM;
    else if (i_host.addr <= `MEM_VID_BIOS_HI)
      dec.region = MR_VID_BIOS;
    else if (i_host.addr <= `MEM_EXP_HI)
      dec.region = MR_EXPANSION;
    else if (i_host.addr <= `MEM_RSVD_HI)
      dec.region = MR_RESERVED;
    else
      dec.region = MR_SYS_BIOS;
    if (i_host.io)
    begin
      // board registers and claimed ports win over expansion
      dec.onboard = reg_space || (ser_claim && i_onboard_dev_en);
      dec.io_fwd  = !dec.onboard && ((|io_hit && !ser_claim) || ser_free);
    end
    else if (i_host.mem)
    begin
      dec.shadow_hit = (i_host.addr >= `MEM_VID_BIOS_LO) && i_shadow_en[blk];
      dec.mem_fwd    = (dec.region == MR_EXPANSION) && !dec.shadow_hit;
      dec.force_8bit = dec.mem_fwd;
    end
  end

  assign o_exp_io_sel  = dec.io_fwd && (i_host.rd || i_host.wr);
  assign o_exp_mem_sel = dec.mem_fwd && (i_host.rd || i_host.wr);
  assign o_exp_8bit    = dec.force_8bit;
  assign o_onboard_sel = dec.onboard;
  assign o_shadow_hit  = dec.shadow_hit;
  assign o_region      = dec.region;
  // sharing blocked: an on-board user of a line masks the card's request
  assign o_irq_to_pic   = i_exp_irq & i_irq_enable & ~i_onboard_irq_use;
  assign o_irq_conflict = i_irq_enable & i_onboard_irq_use;
  assign o_exp_dma_ack  = 1'b0 & i_exp_dma_req;

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.rvalid_r = 1'b0;
    if (i_host.io && i_host.wr && io_addr == `REG_LED_CONTROL)
      state_nxt.led_r = i_host.wdata[`LED_BIT];
    if (i_host.io && i_host.rd && reg_space)
    begin
      state_nxt.rvalid_r = 1'b1;
      case (io_addr)
        `REG_LED_CONTROL: state_nxt.rdata_r = {state_r.led_r, 7'h00};
        `REG_PRODUCT_REV: state_nxt.rdata_r = {PRODUCT_CODE, CIRCUIT_REV};
        default:          state_nxt.rdata_r = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_r <= '0;
      state_r.led_r <= `LED_RESET;
    end
    else if (i_clk_en)
      state_r <= state_nxt;
  end

  assign o_led    = state_r.led_r;
  assign o_rdata  = state_r.rdata_r;
  assign o_rvalid = state_r.rvalid_r;
endmodule

// file: tb/isa_bridge_monitor.sv
// port-level assertions for the expansion bridge
module isa_bridge_monitor
  import isa_bridge_pkg::*;
#(
  parameter logic [4:0] PRODUCT_CODE = 5'h1a,
  parameter logic [2:0] CIRCUIT_REV  = 3'h4
)(
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_clk_en,
  input wire host_cycle_s i_host,
  input wire logic [3:0]  i_ser_enable,
  input wire logic [3:0]  i_exp_irq,
  input wire logic [3:0]  i_irq_enable,
  input wire logic [3:0]  i_onboard_irq_use,
  input wire logic        o_exp_dma_ack,
  input wire logic        o_exp_io_sel,
  input wire logic        o_exp_mem_sel,
  input wire logic        o_exp_8bit,
  input wire logic [3:0]  o_irq_to_pic,
  input wire logic [3:0]  o_irq_conflict,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_rvalid,
  input wire logic        o_led
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [15:0] a = i_host.addr[15:0];
  wire logic io_acc = i_host.io && (i_host.rd || i_host.wr);
  wire logic led_wr = i_clk_en && i_host.io && i_host.wr && a == 16'h01d0;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_dma; !o_exp_dma_ack; endproperty
  a_dma: assert property (p_dma) else $error("dma ack seen");
  property p_led; led_wr |=> o_led == $past(i_host.wdata[7]); endproperty
  a_led: assert property (p_led) else $error("led not set");
  property p_led_hold; !led_wr |=> $stable(o_led); endproperty
  a_led_hold: assert property (p_led_hold) else $error("led moved");
  property p_rd; i_clk_en && i_host.io && i_host.rd && a == 16'h01d1
    |=> o_rvalid && o_rdata == {PRODUCT_CODE, CIRCUIT_REV}; endproperty
  a_rd: assert property (p_rd) else $error("bad product read");
  property p_conf; o_irq_conflict == (i_irq_enable & i_onboard_irq_use); endproperty
  a_conf: assert property (p_conf) else $error("bad conflict");
  property p_pic; o_irq_to_pic == (i_exp_irq & i_irq_enable & ~i_onboard_irq_use); endproperty
  a_pic: assert property (p_pic) else $error("bad irq pass");
  property p_mem; o_exp_mem_sel |-> o_exp_8bit && i_host.addr inside {[20'hd0000:20'hdbfff]}; endproperty
  a_mem: assert property (p_mem) else $error("bad mem fwd");
  // an enabled serial port inside the range keeps its addresses off the expansion bus
  property p_io_fwd; io_acc && a inside {[16'h0200:16'h036f]}
    && !(i_ser_enable[1] && (a & 16'hfff8) == 16'h02f8)
    && !(i_ser_enable[3] && (a & 16'hfff8) == 16'h02e8) |-> o_exp_io_sel; endproperty
  a_io_fwd: assert property (p_io_fwd) else $error("io not fwd");
  property p_io_own; io_acc && a inside {[16'h01d0:16'h01de]} |-> !o_exp_io_sel; endproperty
  a_io_own: assert property (p_io_own) else $error("board io fwd");
endmodule
bind isa_expansion_decode_board_regs isa_bridge_monitor #(
  .PRODUCT_CODE(PRODUCT_CODE),
  .CIRCUIT_REV(CIRCUIT_REV)
) u_isa_bridge_monitor (.i_clk, .i_sys_rst, .i_clk_en, .i_host, .i_ser_enable, .i_exp_irq, .i_irq_enable,
  .i_onboard_irq_use, .o_exp_dma_ack, .o_exp_io_sel, .o_exp_mem_sel, .o_exp_8bit,
  .o_irq_to_pic, .o_irq_conflict, .o_rdata, .o_rvalid, .o_led);

// file: tb/exp_card_model.sv
// plug-in card model: irq and dma request lines
module exp_card_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_irq_cmd,
  input  wire logic       i_dma_cmd,
  output logic [3:0]      o_exp_irq,
  output logic            o_exp_dma_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // a card owns its line; dma asked for though never served
  always_ff @(posedge i_clk)
  begin
    o_exp_irq     <= i_irq_cmd;
    o_exp_dma_req <= i_dma_cmd;
  end
endmodule

// file: tb/test_isa_expansion_decode_board_regs.sv
// testbench for the expansion bridge
module test_isa_expansion_decode_board_regs
  import isa_bridge_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] PC = 5'h0b; // arbitrary value
  localparam logic [2:0] RV = 3'h6;  // arbitrary value
  localparam logic [11:0] IO_A [13] = '{12'h100, 12'h1cf, 12'h1d0, 12'h1de, 12'h1df, 12'h1f0, 12'h36f,
    12'h370, 12'h400, 12'h480, 12'h4d2, 12'haff, 12'hb00};
  localparam logic [12:0] IO_E = 13'b0110101010011;
  localparam logic [12:0] IO_O = 13'b0000000001100;
  localparam logic [11:0] SER_A [4] = '{12'h3f8, 12'h2f8, 12'h3e8, 12'h2e8};
  localparam logic [19:0] MEM_A [8] = '{20'hd0000, 20'hdbfff, 20'hdc000, 20'h9ffff, 20'ha0000,
    20'hc0000, 20'he0000, 20'hfffff};
  localparam mem_region_e MEM_R [8] = '{MR_EXPANSION, MR_EXPANSION, MR_RESERVED, MR_SYS_RAM,
    MR_VID_RAM, MR_VID_BIOS, MR_SYS_BIOS, MR_SYS_BIOS};
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_exp_dma_req, o_exp_dma_ack, o_exp_io_sel, o_exp_mem_sel;
  logic o_exp_8bit, o_onboard_sel, o_shadow_hit, o_rvalid, o_led;
  logic [3:0] i_ser_enable = 4'hf, i_irq_enable = 4'h0, i_onboard_irq_use = 4'h0;
  logic [3:0] i_exp_irq, o_irq_to_pic, o_irq_conflict;
  logic [3:0] irq_cmd = 4'hf;
  logic clk_en = 1'b1, onboard_en = 1'b1;
  logic [15:0] shadow_en = 16'h0000;
  logic [7:0] o_rdata;
  host_cycle_s i_host = '0;
  mem_region_e o_region;
  int failures = 0, comparisons = 0, cycles = 0;
  exp_card_model u_exp_card_model (.i_clk, .i_irq_cmd(irq_cmd), .i_dma_cmd(1'b1),
    .o_exp_irq(i_exp_irq), .o_exp_dma_req(i_exp_dma_req));
  isa_expansion_decode_board_regs #(.PRODUCT_CODE(PC), .CIRCUIT_REV(RV)) u_isa_expansion_decode_board_regs (
    .i_clk, .i_sys_rst, .i_clk_en(clk_en), .i_host, .i_ser_enable, .i_onboard_dev_en(onboard_en),
    .i_shadow_en(shadow_en), .i_irq_enable, .i_onboard_irq_use, .i_exp_irq, .i_exp_dma_req,
    .o_exp_dma_ack, .o_exp_io_sel, .o_exp_mem_sel, .o_exp_8bit, .o_onboard_sel, .o_shadow_hit,
    .o_region, .o_irq_to_pic, .o_irq_conflict, .o_rdata, .o_rvalid, .o_led);
  always #4 i_clk = ~i_clk;
  task automatic summarize();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    if (g !== e)
      failures++;
  endtask
  // one io register access; outputs are settled on return
  task automatic acc(input logic r, input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    i_host = '{io: 1'b1, mem: 1'b0, rd: r, wr: !r, addr: {8'h00, a}, wdata: d, wide: 1'b0};
    @(posedge i_clk);
    #1;
    i_host = '0;
  endtask
  // decode outputs are combinational, looked at within the cycle
  task automatic dec(input logic m, input logic [19:0] a, input logic [3:0] s, input logic [7:0] e);
    @(posedge i_clk);
    #1;
    i_ser_enable = s;
    i_host = '{io: !m, mem: m, rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00, wide: 1'b0};
    #1;
    chk(m ? {3'h0, o_exp_8bit, o_region, o_exp_mem_sel} : {6'h0, o_onboard_sel, o_exp_io_sel}, e);
  endtask
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      summarize();
    end
  end
  initial
  begin
    repeat (4) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    chk({7'h0, o_led}, 8'h00);
    acc(1'b1, 12'h1d0, 8'h00);
    chk({6'h0, o_rvalid, o_rdata[7]}, 8'h02);
    acc(1'b0, 12'h1d0, 8'h80);
    chk({7'h0, o_led}, 8'h01);
    acc(1'b0, 12'h1d0, 8'h7f);
    chk({7'h0, o_led}, 8'h00);
    acc(1'b0, 12'h1d1, 8'h00);
    acc(1'b1, 12'h1d1, 8'h00);
    chk(o_rdata, {PC, RV});
    // frozen clock enable must keep the led where it is
    @(posedge i_clk);
    #1;
    clk_en = 1'b0;
    acc(1'b0, 12'h1d0, 8'h80);
    chk({7'h0, o_led}, 8'h00);
    clk_en = 1'b1;
    $display("test registers done");
    foreach (IO_A[i]) dec(1'b0, {8'h00, IO_A[i]}, 4'hf, {6'h0, IO_O[i], IO_E[i]});
    foreach (SER_A[i]) dec(1'b0, {8'h00, SER_A[i]}, ~(4'h1 << i), 8'h01);
    foreach (SER_A[i]) dec(1'b0, {8'h00, SER_A[i]} + 20'h7, 4'hf, 8'h02);
    foreach (MEM_A[i])
      dec(1'b1, MEM_A[i], 4'hf, {3'h0, MEM_R[i] == MR_EXPANSION, MEM_R[i], MEM_R[i] == MR_EXPANSION});
    @(posedge i_clk);
    #1;
    onboard_en = 1'b0;
    shadow_en = 16'h0010;
    dec(1'b0, 20'h003f8, 4'hf, 8'h00);
    dec(1'b0, 20'h001d2, 4'hf, 8'h02);
    dec(1'b1, 20'hd0000, 4'hf, {3'h0, 1'b0, MR_EXPANSION, 1'b0});
    chk({7'h0, o_shadow_hit}, 8'h01);
    dec(1'b1, 20'h90000, 4'hf, {3'h0, 1'b0, MR_SYS_RAM, 1'b0});
    chk({7'h0, o_shadow_hit}, 8'h00);
    $display("test decode done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge i_clk);
      #1;
      i_irq_enable = 4'(1 << i);
      #1;
      chk({o_irq_to_pic, o_irq_conflict}, {i_irq_enable, 4'h0});
    end
    chk({7'h0, o_exp_dma_ack}, 8'h00);
    @(posedge i_clk);
    #1;
    i_irq_enable = 4'h9;
    i_onboard_irq_use = 4'h1;
    #1;
    chk({o_irq_to_pic, o_irq_conflict}, 8'h81);
    // card drops irq 10: nothing may reach the controller
    @(posedge i_clk);
    #1;
    irq_cmd = 4'h7;
    @(posedge i_clk);
    #1;
    chk({o_irq_to_pic, o_irq_conflict}, 8'h01);
    $display("test interrupts done");
    summarize();
  end
endmodule
